// ===== rtl/pfc_map.svh
// Operation
// (RULE1) Function code is valid only while the strobe is low, one strobe cycle each.
// (RULE2) Idle code goes out in every strobe cycle without data or control use.
// (RULE3) Inbound data is captured on the strobe rising edge.
// (RULE4) Peripheral pulls data lines low only around the sampling strobe edge.
// (RULE5) Register A/B/C output codes carry the output word driven on the data bus.
// (RULE6) Selected start, clear or pulse code follows a data code in the next cycle.
// (RULE7) No-transfer instruction sends idle in the data slot, then any control code.
// (RULE8) Register A/B/C input codes: peripheral drives bus, sampled on rising strobe.
// (RULE9) Mask and reset-config codes: peripheral drives data, sampled on rising strobe.
// (RULE10) Each channel word is one address transfer then one data transfer.
// (RULE11) Address phase: direction on bit 0, address on bits 1 to 15.
// (RULE12) Sampled address bits are ignored when the internal address register is used.
// (RULE13) Direction 0 is out to peripheral, direction 1 is in from peripheral.
// (RULE14) Inbound channel: inbound code in second transfer, data sampled on rising strobe.
// (RULE15) Outbound channel: outbound code in second transfer with memory word driven.
// (RULE16) Count-zero code is sent when the word counter overflows to zero.
// (RULE17) Gap from address phase to data phase stays within the bounded maximum.
// (RULE18) The transmitting side generates the serial bit clock; receiver samples on it.
// (RULE19) Transceiver direction is low to transmit, high to receive, receive by default.
// (RULE20) Peripheral should clear busy and done on clear or reset code.
// (RULE21) Every command is one of sixteen codes on four function code lines.
// (RULE22) Skip and interrupt acknowledge produce no function code.
// (RULE23) Control field: 00 none, 01 start, 10 clear, 11 pulse.
// (RULE24) Data bus is released whenever the block does not drive an output word.
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH
// Function codes
`define PFC_FC_LOAD_A    4'h0
`define PFC_FC_READ_A    4'h1
`define PFC_FC_LOAD_B    4'h2
`define PFC_FC_READ_B    4'h3
`define PFC_FC_LOAD_C    4'h4
`define PFC_FC_READ_C    4'h5
`define PFC_FC_GO        4'h6
`define PFC_FC_WIPE      4'h7
`define PFC_FC_PULSE     4'h8
`define PFC_FC_CFG_RST   4'h9
`define PFC_FC_MASK      4'hA
`define PFC_FC_CH_ADDR   4'hB
`define PFC_FC_CH_IN     4'hC
`define PFC_FC_CH_OUT    4'hD
`define PFC_FC_CNT_ZERO  4'hE
`define PFC_FC_IDLE      4'hF
// Register byte addresses
`define PFC_A_CMD        8'h00
`define PFC_A_CFG        8'h04
`define PFC_A_OUT        8'h08
`define PFC_A_IN         8'h0C
`define PFC_A_CHAN       8'h10
`define PFC_A_ADDR       8'h14
`define PFC_A_WCNT       8'h18
`define PFC_A_STAT       8'h1C
`define PFC_A_TXD        8'h20
`define PFC_A_RXD        8'h24
// Timing: half periods in pclk cycles, channel gap in strobe cycles, frame length in bits
`define PFC_STB_HALF     4
`define PFC_CH_GAP       2
`define PFC_BIT_HALF     4
`define PFC_FRAME_BITS   9
`endif

// ===== rtl/pfc_pkg.sv
package pfc_pkg;
  typedef enum logic [2:0] {
    PFC_IDLE = 3'h0,
    PFC_DATA = 3'h1,
    PFC_CTRL = 3'h3,
    PFC_CHA  = 3'h4,
    PFC_WAIT = 3'h5,
    PFC_XFER = 3'h7
  } pfc_state_e;
  typedef enum logic [3:0] {
    PFC_OP_NIO   = 4'h0,
    PFC_OP_RDA   = 4'h1,
    PFC_OP_LDA   = 4'h2,
    PFC_OP_RDB   = 4'h3,
    PFC_OP_LDB   = 4'h4,
    PFC_OP_RDC   = 4'h5,
    PFC_OP_LDC   = 4'h6,
    PFC_OP_SKIP  = 4'h7,
    PFC_OP_MASK  = 4'h8,
    PFC_OP_CRST  = 4'h9,
    PFC_OP_IACK  = 4'hA,
    PFC_OP_CHAN  = 4'hB
  } pfc_op_e;
endpackage : pfc_pkg

// ===== rtl/pfc_port.sv
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_map.svh"
module pfc_port
  import pfc_pkg::*;
#(
  parameter int STB_HALF  = `PFC_STB_HALF,
  parameter int CH_GAP    = `PFC_CH_GAP,
  parameter int BIT_HALF  = `PFC_BIT_HALF
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Peripheral port
  output logic [3:0]       func_code,
  output logic             code_qualify_strobe,
  input  wire logic [15:0] pdata_in,
  output logic [15:0]      pdata_out,
  output logic             pdata_oe,
  // Serial link
  input  wire logic        io_clk_in,
  input  wire logic        io_data1_in,
  input  wire logic        io_data2_in,
  output logic             io_clk_out,
  output logic             io_data1_out,
  output logic             io_data2_out,
  output logic             io_input
);

  localparam logic [7:0] STB_LAST = 8'(2 * STB_HALF - 1);
  localparam logic [7:0] STB_PRE  = 8'(STB_HALF - 1);
  localparam logic [7:0] STB_RISE = 8'(STB_HALF);
  localparam logic [7:0] STB_LOAD = 8'(STB_HALF + 1);
  localparam logic [7:0] GAP_LAST = 8'(CH_GAP - 1);
  localparam logic [7:0] BIT_LAST = 8'(BIT_HALF - 1);

  // Strobe divider: low half carries the code, rise samples
  logic [7:0] ph_r;
  logic       tick_rise;
  logic       tick_load;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Start in the high half so the strobe's reset level fits the phase
      ph_r <= STB_RISE;
    end else if (ph_r == STB_LAST) begin
      ph_r <= 8'h00;
    end else begin
      ph_r <= ph_r + 8'h01;
    end
  end

  assign tick_rise = (ph_r == STB_RISE);
  // Code changes mid-high so it is settled before the strobe falls
  assign tick_load = (ph_r == STB_LOAD);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_qualify_strobe <= 1'b1;
    end else begin
      code_qualify_strobe <= (ph_r >= STB_PRE) && (ph_r != STB_LAST); // see (RULE1)
    end
  end

  // Pin synchronisers
  logic [15:0] pd_s1_r, pd_s2_r;
  logic [2:0]  ln_s1_r, ln_s2_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_s1_r <= 16'hFFFF;
      pd_s2_r <= 16'hFFFF;
      ln_s1_r <= 3'h0;
      ln_s2_r <= 3'h0;
    end else begin
      pd_s1_r <= pdata_in;
      pd_s2_r <= pd_s1_r;
      ln_s1_r <= {io_clk_in, io_data1_in, io_data2_in};
      ln_s2_r <= ln_s1_r;
    end
  end

  // Software-facing state
  logic        cmd_pend_r;
  pfc_op_e     cmd_op_r;
  logic [1:0]  cmd_ctl_r;
  logic        cfg_int_addr_r;
  logic        cfg_wc_en_r;
  logic [15:0] out_word_r;
  logic [15:0] in_word_r;
  logic        chan_dir_r;
  logic [14:0] chan_addr_r;
  logic [14:0] int_addr_r;
  logic [15:0] wcnt_r;
  logic        count_zero_code_seen_r;
  logic [17:0] rx_shift_r;
  logic [3:0]  rx_cnt_r;

  // Sequencer
  pfc_state_e  st_r;
  logic [7:0]  gap_r;
  logic        ch_step;
  logic        cmd_done;
  logic        wc_wrap;

  function automatic logic [3:0] ctl_code(input logic [1:0] f);
    unique case (f)
      2'b01:   ctl_code = `PFC_FC_GO;
      2'b10:   ctl_code = `PFC_FC_WIPE;
      2'b11:   ctl_code = `PFC_FC_PULSE;
      default: ctl_code = `PFC_FC_IDLE;
    endcase
  endfunction : ctl_code

  assign wc_wrap  = cfg_wc_en_r && (wcnt_r == 16'hFFFF);
  assign ch_step  = tick_load && (st_r == PFC_CHA);
  assign cmd_done = tick_load && cmd_pend_r &&
                    ((st_r == PFC_IDLE && (cmd_op_r == PFC_OP_SKIP ||
                                           cmd_op_r == PFC_OP_IACK ||
                                           cmd_op_r > PFC_OP_CHAN)) ||
                     (st_r == PFC_DATA && cmd_ctl_r == 2'b00) ||
                     st_r == PFC_CTRL || st_r == PFC_XFER);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= PFC_IDLE;
      func_code <= `PFC_FC_IDLE;
      gap_r     <= 8'h00;
    end else if (tick_load) begin
      func_code <= `PFC_FC_IDLE; // see (RULE2) (RULE21)
      unique case (st_r)
        PFC_IDLE: begin
          if (cmd_pend_r) begin
            st_r <= PFC_DATA;
            unique case (cmd_op_r)
              PFC_OP_NIO:  func_code <= `PFC_FC_IDLE; // see (RULE7)
              PFC_OP_RDA:  func_code <= `PFC_FC_READ_A; // see (RULE8)
              PFC_OP_LDA:  func_code <= `PFC_FC_LOAD_A; // see (RULE5)
              PFC_OP_RDB:  func_code <= `PFC_FC_READ_B;
              PFC_OP_LDB:  func_code <= `PFC_FC_LOAD_B;
              PFC_OP_RDC:  func_code <= `PFC_FC_READ_C;
              PFC_OP_LDC:  func_code <= `PFC_FC_LOAD_C;
              PFC_OP_MASK: func_code <= `PFC_FC_MASK; // see (RULE9)
              PFC_OP_CRST: func_code <= `PFC_FC_CFG_RST;
              PFC_OP_CHAN: begin
                func_code <= `PFC_FC_CH_ADDR; // see (RULE10)
                st_r      <= PFC_CHA;
              end
              default: st_r <= PFC_IDLE; // see (RULE22)
            endcase
          end
        end
        PFC_DATA: begin
          if (cmd_ctl_r != 2'b00) begin
            func_code <= ctl_code(cmd_ctl_r); // see (RULE6) (RULE23)
            st_r      <= PFC_CTRL;
          end else begin
            st_r <= PFC_IDLE;
          end
        end
        PFC_CTRL: st_r <= PFC_IDLE;
        PFC_CHA: begin
          if (wc_wrap) begin
            func_code <= `PFC_FC_CNT_ZERO; // see (RULE16)
          end
          gap_r <= 8'h00;
          st_r  <= PFC_WAIT;
        end
        PFC_WAIT: begin
          // Fixed gap keeps the address-to-data delay bounded
          if (gap_r >= GAP_LAST) begin // see (RULE17)
            func_code <= chan_dir_r ? `PFC_FC_CH_IN : `PFC_FC_CH_OUT; // see (RULE13) (RULE14) (RULE15)
            st_r      <= PFC_XFER;
          end else begin
            gap_r <= gap_r + 8'h01;
          end
        end
        PFC_XFER: st_r <= PFC_IDLE;
        default:  st_r <= PFC_IDLE;
      endcase
    end
  end

  // Output word is driven only with load codes and the outbound channel code
  logic drive_now;
  assign drive_now = (func_code == `PFC_FC_LOAD_A) || (func_code == `PFC_FC_LOAD_B) ||
                     (func_code == `PFC_FC_LOAD_C) || (func_code == `PFC_FC_CH_OUT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdata_oe  <= 1'b0;
      pdata_out <= 16'h0000;
    end else begin
      pdata_oe  <= drive_now; // see (RULE24)
      pdata_out <= drive_now ? out_word_r : 16'h0000; // see (RULE5) (RULE15)
    end
  end

  // Inbound capture on the strobe rise
  logic sample_now;
  assign sample_now = tick_rise &&
                      ((func_code == `PFC_FC_READ_A) || (func_code == `PFC_FC_READ_B) ||
                       (func_code == `PFC_FC_READ_C) || (func_code == `PFC_FC_MASK) ||
                       (func_code == `PFC_FC_CFG_RST) || (func_code == `PFC_FC_CH_IN));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_word_r   <= 16'h0000;
      chan_dir_r  <= 1'b0;
      chan_addr_r <= 15'h0000;
    end else if (sample_now) begin
      in_word_r <= pd_s2_r; // see (RULE3) (RULE8) (RULE9) (RULE14)
    end else if (tick_rise && func_code == `PFC_FC_CH_ADDR) begin
      chan_dir_r <= pd_s2_r[0]; // see (RULE11)
      // Internal address mode discards the sampled address bits
      chan_addr_r <= cfg_int_addr_r ? int_addr_r : pd_s2_r[15:1]; // see (RULE12)
    end
  end

  // Serial transmit: this end drives the bit clock while sending
  logic        tx_go;
  logic [15:0] tx_word;
  logic [1:0]  tx_type;
  logic        tx_busy_r;
  logic [8:0]  tx_sh1_r, tx_sh2_r;
  logic [3:0]  tx_bits_r;
  logic [7:0]  tx_ph_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy_r    <= 1'b0;
      tx_sh1_r     <= 9'h000;
      tx_sh2_r     <= 9'h000;
      tx_bits_r    <= 4'h0;
      tx_ph_r      <= 8'h00;
      io_clk_out   <= 1'b0;
      io_data1_out <= 1'b0;
      io_data2_out <= 1'b0;
    end else if (!tx_busy_r) begin
      io_clk_out <= 1'b0;
      if (tx_go) begin
        // Type bits stand before the first rise, the rest follow each fall but the last
        tx_busy_r    <= 1'b1;
        io_data1_out <= tx_type[1];
        io_data2_out <= tx_type[0];
        tx_sh1_r     <= {tx_word[15:8], 1'b0};
        tx_sh2_r     <= {tx_word[7:0], 1'b0};
        tx_bits_r <= 4'h0;
        tx_ph_r   <= 8'h00;
      end
    end else if (tx_ph_r == BIT_LAST) begin
      tx_ph_r    <= 8'h00;
      io_clk_out <= ~io_clk_out; // see (RULE18)
      if (!io_clk_out) begin
        tx_bits_r <= tx_bits_r + 4'h1;
      end else if (tx_bits_r == 4'(`PFC_FRAME_BITS)) begin
        tx_busy_r <= 1'b0;
      end else begin
        // Data changes on the falling edge, receiver samples the rise
        io_data1_out <= tx_sh1_r[8];
        io_data2_out <= tx_sh2_r[8];
        tx_sh1_r     <= {tx_sh1_r[7:0], 1'b0};
        tx_sh2_r     <= {tx_sh2_r[7:0], 1'b0};
      end
    end else begin
      tx_ph_r <= tx_ph_r + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_input <= 1'b1;
    end else begin
      io_input <= ~(tx_busy_r || tx_go); // see (RULE19)
    end
  end

  // Serial receive on the far clock's rising edge
  logic clk_d_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_d_r    <= 1'b0;
      rx_shift_r <= 18'h00000;
      rx_cnt_r   <= 4'h0;
    end else begin
      clk_d_r <= ln_s2_r[2];
      if (io_input && ln_s2_r[2] && !clk_d_r) begin // see (RULE18)
        rx_shift_r <= {rx_shift_r[16:9], ln_s2_r[1], rx_shift_r[7:0], ln_s2_r[0]};
        rx_cnt_r   <= (rx_cnt_r == 4'hF) ? rx_cnt_r : rx_cnt_r + 4'h1;
      end
    end
  end

  // APB slave: zero wait states, error on unmapped address
  logic apb_wr, apb_rd, mapped;
  assign pready  = 1'b1;
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && penable && !pwrite;
  assign mapped  = (paddr <= `PFC_A_RXD) && (paddr[1:0] == 2'b00);
  assign pslverr = psel && penable && !mapped;
  assign tx_go   = apb_wr && (paddr == `PFC_A_TXD) && !tx_busy_r;
  assign tx_word = pwdata[15:0];
  assign tx_type = pwdata[17:16];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_pend_r     <= 1'b0;
      cmd_op_r       <= PFC_OP_NIO;
      cmd_ctl_r      <= 2'b00;
      cfg_int_addr_r <= 1'b0;
      cfg_wc_en_r    <= 1'b0;
      out_word_r     <= 16'h0000;
      int_addr_r     <= 15'h0000;
      wcnt_r         <= 16'h0000;
      count_zero_code_seen_r    <= 1'b0;
    end else begin
      if (cmd_done) begin
        cmd_pend_r <= 1'b0;
      end else if (apb_wr && paddr == `PFC_A_CMD && !cmd_pend_r) begin
        cmd_pend_r <= 1'b1;
        cmd_op_r   <= pfc_op_e'(pwdata[3:0]);
        // Config and mask reads carry no trailing control code
        cmd_ctl_r  <= (pwdata[3:0] == 4'h8 || pwdata[3:0] == 4'h9) ? 2'b00 : pwdata[5:4];
      end
      if (apb_wr && paddr == `PFC_A_CFG) begin
        cfg_int_addr_r <= pwdata[0];
        cfg_wc_en_r    <= pwdata[1];
      end
      if (apb_wr && paddr == `PFC_A_OUT) begin
        out_word_r <= pwdata[15:0];
      end
      if (ch_step && cfg_int_addr_r) begin
        int_addr_r <= int_addr_r + 15'h0001;
      end else if (apb_wr && paddr == `PFC_A_ADDR) begin
        int_addr_r <= pwdata[14:0];
      end
      if (ch_step && cfg_wc_en_r) begin
        wcnt_r <= wcnt_r + 16'h0001; // see (RULE16)
      end else if (apb_wr && paddr == `PFC_A_WCNT) begin
        wcnt_r <= pwdata[15:0];
      end
      // Set wins over a same-cycle clear
      if (ch_step && wc_wrap) begin
        count_zero_code_seen_r <= 1'b1;
      end else if (apb_wr && paddr == `PFC_A_STAT && pwdata[1]) begin
        count_zero_code_seen_r <= 1'b0;
      end
    end
  end

  always_comb begin
    prdata = 32'h00000000;
    if (apb_rd) begin
      unique case (paddr)
        `PFC_A_CMD:  prdata = {26'h0, cmd_ctl_r, cmd_op_r};
        `PFC_A_CFG:  prdata = {30'h0, cfg_wc_en_r, cfg_int_addr_r};
        `PFC_A_OUT:  prdata = {16'h0, out_word_r};
        `PFC_A_IN:   prdata = {16'h0, in_word_r};
        `PFC_A_CHAN: prdata = {16'h0, chan_addr_r, chan_dir_r};
        `PFC_A_ADDR: prdata = {17'h0, int_addr_r};
        `PFC_A_WCNT: prdata = {16'h0, wcnt_r};
        `PFC_A_STAT: prdata = {25'h0, st_r, io_input, tx_busy_r, count_zero_code_seen_r, cmd_pend_r};
        `PFC_A_RXD:  prdata = {10'h0, rx_cnt_r, rx_shift_r};
        default:     prdata = 32'h00000000;
      endcase
    end
  end

endmodule : pfc_port
`default_nettype wire

// ===== tb/pfc_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfc_map.svh"
module pfc_port_monitor (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Peripheral port
  input wire logic [3:0]  func_code,
  input wire logic        code_qualify_strobe,
  input wire logic [15:0] pdata_out,
  input wire logic        pdata_oe,
  // Serial link
  input wire logic        io_clk_out,
  input wire logic        io_input
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic       stb = code_qualify_strobe;
  wire logic [3:0] fc  = func_code;
  wire logic       drv = fc inside {`PFC_FC_LOAD_A, `PFC_FC_LOAD_B, `PFC_FC_LOAD_C, `PFC_FC_CH_OUT};
  sequence s_low;  !stb [*4]; endsequence
  sequence s_high; stb [*4]; endsequence
  a_strobe_cycle: assert property ($fell(stb) |-> s_low ##1 s_high ##1 !stb)
    else $error("Strobe period wrong");
  a_code_steady: assert property (!$stable(fc) |-> stb && $past(stb))
    else $error("Code changed in valid half");
  a_oe_codes: assert property (pdata_oe == $past(drv))
    else $error("Bus drive does not match code");
  // Only within one code: back-to-back load codes may change the word
  a_out_steady: assert property (
    pdata_oe && $past(pdata_oe) && $past(fc) == $past(fc, 2) |-> $stable(pdata_out))
    else $error("Output word moved under its code");
  a_ctrl_slot: assert property (
    !$stable(fc) && fc inside {[`PFC_FC_GO:`PFC_FC_PULSE]}
    |-> $past(fc) inside {[`PFC_FC_LOAD_A:`PFC_FC_READ_C], `PFC_FC_IDLE})
    else $error("Control code without data slot");
  a_idle_after: assert property (
    !$stable(fc) && $past(fc) inside {[`PFC_FC_GO:`PFC_FC_MASK], `PFC_FC_CH_IN, `PFC_FC_CH_OUT}
    |-> fc == `PFC_FC_IDLE)
    else $error("No idle after final code");
  a_chan_next: assert property (
    !$stable(fc) && $past(fc) == `PFC_FC_CH_ADDR |-> fc inside {`PFC_FC_CNT_ZERO, `PFC_FC_IDLE})
    else $error("Wrong code after address phase");
  a_chan_gap: assert property (
    !$stable(fc) && fc == `PFC_FC_CH_ADDR |-> ##[8:24] fc inside {`PFC_FC_CH_IN, `PFC_FC_CH_OUT})
    else $error("Data phase late");
  a_tx_dir: assert property (!$stable(io_clk_out) |-> !io_input)
    else $error("Link clock driven in receive mode");
endmodule : pfc_port_monitor
bind pfc_port pfc_port_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .func_code(func_code),
  .code_qualify_strobe(code_qualify_strobe), .pdata_out(pdata_out),
  .pdata_oe(pdata_oe), .io_clk_out(io_clk_out), .io_input(io_input)
);
`default_nettype wire

// ===== tb/pfc_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfc_map.svh"
module pfc_periph_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Port pins
  input  wire logic [3:0]  func_code,
  input  wire logic        code_qualify_strobe,
  input  wire logic [15:0] pdata_out,
  input  wire logic        pdata_oe,
  output logic [15:0]      pdata_in,
  // Words gated back
  input  wire logic [15:0] mask_val,
  input  wire logic [15:0] cfg_val,
  input  wire logic [15:0] chan_word,
  input  wire logic [15:0] chan_data,
  // Observed state
  output logic [2:0][15:0] regs_q,
  output logic [15:0]      ch_out_q,
  output logic [3:0]       last_code,
  output logic [7:0]       n_codes,
  output logic             busy,
  output logic             done
);
  logic        stb_q;
  logic        hold_q;
  logic [15:0] gate;
  wire logic [15:0] bus  = pdata_oe ? pdata_out : 16'hFFFF;
  wire logic        rise = code_qualify_strobe && !stb_q;
  always_comb begin
    case (func_code)
      `PFC_FC_READ_A:  gate = regs_q[0];
      `PFC_FC_READ_B:  gate = regs_q[1];
      `PFC_FC_READ_C:  gate = regs_q[2];
      `PFC_FC_MASK:    gate = mask_val;
      `PFC_FC_CFG_RST: gate = cfg_val;
      `PFC_FC_CH_ADDR: gate = chan_word;
      `PFC_FC_CH_IN:   gate = chan_data;
      default:         gate = 16'hFFFF;
    endcase
  end
  // Pull-ups win outside the valid half and one hold cycle
  assign pdata_in = (!code_qualify_strobe || hold_q) ? gate : 16'hFFFF;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_q     <= 1'b1;
      hold_q    <= 1'b0;
      regs_q    <= '0;
      ch_out_q  <= 16'h0000;
      last_code <= `PFC_FC_IDLE;
      n_codes   <= 8'h00;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      stb_q  <= code_qualify_strobe;
      hold_q <= !code_qualify_strobe;
      // Decode only where the strobe closes a valid code
      if (rise && func_code != `PFC_FC_IDLE) begin
        last_code <= func_code;
        n_codes   <= n_codes + 8'h01;
        case (func_code)
          `PFC_FC_LOAD_A:  regs_q[0] <= bus;
          `PFC_FC_LOAD_B:  regs_q[1] <= bus;
          `PFC_FC_LOAD_C:  regs_q[2] <= bus;
          `PFC_FC_CH_OUT:  ch_out_q <= bus;
          `PFC_FC_GO:      busy <= 1'b1;
          `PFC_FC_CNT_ZERO: done <= 1'b1;
          `PFC_FC_WIPE, `PFC_FC_CFG_RST: begin
            busy <= 1'b0;
            done <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end
endmodule : pfc_periph_model
`default_nettype wire

// ===== tb/pfc_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfc_map.svh"
module pfc_port_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, perr, code_qualify_strobe, pdata_oe, busy, done;
  logic io_clk_in = 1'b0, io_d1 = 1'b0, io_d2 = 1'b0, io_clk_out, io_data1_out;
  logic io_data2_out, io_input;
  logic [3:0]  func_code, last_code;
  logic [15:0] pdata_in, pdata_out, ch_out_q;
  logic [15:0] mask_val = 16'h0, cfg_val = 16'h0, chan_word = 16'h0, chan_data = 16'h0;
  logic [2:0][15:0] regs_q, sh = '0;
  logic [7:0]  n_codes;
  int mismatches = 0, n_checks = 0;
  always #20 pclk = ~pclk;
  pfc_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .func_code(func_code), .code_qualify_strobe(code_qualify_strobe),
    .pdata_in(pdata_in), .pdata_out(pdata_out), .pdata_oe(pdata_oe), .io_clk_in(io_clk_in),
    .io_data1_in(io_d1), .io_data2_in(io_d2), .io_clk_out(io_clk_out),
    .io_data1_out(io_data1_out), .io_data2_out(io_data2_out), .io_input(io_input));
  pfc_periph_model peer (.pclk(pclk), .presetn(presetn), .func_code(func_code),
    .code_qualify_strobe(code_qualify_strobe), .pdata_out(pdata_out), .pdata_oe(pdata_oe),
    .pdata_in(pdata_in), .mask_val(mask_val), .cfg_val(cfg_val), .chan_word(chan_word),
    .chan_data(chan_data), .regs_q(regs_q), .ch_out_q(ch_out_q), .last_code(last_code),
    .n_codes(n_codes), .busy(busy), .done(done));
  task automatic conclude;
    $display("Counts: %0d checks, %0d mismatches", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run_cmd(input logic [3:0] op, input logic [1:0] f);
    int t;
    t = 0;
    apb(1'b1, `PFC_A_CMD, {26'h0, f, op});
    do begin
      apb(1'b0, `PFC_A_STAT, 32'h0);
      t++;
    end while (rd[0] !== 1'b0 && t < 40);
    chk(rd[0], 1'b0);
    repeat (56) @(posedge pclk);
  endtask : run_cmd
  function automatic logic [3:0] code_of(input logic [3:0] op);
    if (op == 4'h8) return `PFC_FC_MASK;
    if (op == 4'h9) return `PFC_FC_CFG_RST;
    return op[0] ? op : op - 4'h2;
  endfunction : code_of
  initial begin
    #2000000;
    mismatches++;
    conclude();
  end
  initial begin
    logic [15:0] w, w2;
    logic [1:0]  f;
    logic [7:0]  n0;
    logic [3:0]  l0;
    logic [8:0]  r1, r2, g1, g2;
    logic        dat, ctl, dir, wrap, cq;
    int          t, k;
    w = $urandom(32'h7FE0);
    repeat (5) @(posedge pclk);
    chk({func_code, pdata_oe, io_input}, {`PFC_FC_IDLE, 2'b01});
    presetn <= 1'b1;
    apb(1'b0, 8'h40, 32'h0);
    chk(perr, 1'b1);
    $display("Test reset done");
    for (int p = 0; p < 3; p++) begin
      for (int op = 0; op < 11; op++) begin
        f = $urandom;
        w = $urandom;
        mask_val <= $urandom;
        cfg_val  <= $urandom;
        apb(1'b1, `PFC_A_OUT, {16'h0, w});
        n0 = n_codes;
        l0 = last_code;
        run_cmd(op[3:0], f);
        dat = op inside {[1:6], 8, 9};
        ctl = op < 7 && f != 2'b00;
        chk(n_codes, n0 + dat + ctl);
        chk(last_code, ctl ? 4'h5 + f : dat ? code_of(op[3:0]) : l0);
        if (op inside {2, 4, 6}) begin
          sh[op / 2 - 1] = w;
          chk(regs_q[op / 2 - 1], w);
        end
        if (op inside {1, 3, 5, 8, 9}) begin
          apb(1'b0, `PFC_A_IN, 32'h0);
          chk(rd, op == 8 ? mask_val : op == 9 ? cfg_val : sh[(op - 1) / 2]);
        end
      end
    end
    $display("Test programmed codes done");
    for (int i = 0; i < 4; i++) begin
      dir = i[0];
      wrap = i[1];
      w = $urandom;
      w2 = $urandom;
      chan_word <= {w[15:1], dir};
      chan_data <= $urandom;
      apb(1'b1, `PFC_A_OUT, {16'h0, w2});
      apb(1'b1, `PFC_A_WCNT, wrap ? 32'hFFFF : 32'h0);
      apb(1'b1, `PFC_A_CFG, {30'h0, 1'b1, wrap});
      apb(1'b1, `PFC_A_ADDR, {17'h0, w2[14:0]});
      n0 = n_codes;
      run_cmd(4'hB, 2'b00);
      chk(n_codes, n0 + 8'd2 + wrap);
      chk(last_code, dir ? `PFC_FC_CH_IN : `PFC_FC_CH_OUT);
      apb(1'b0, `PFC_A_CHAN, 32'h0);
      chk(rd, {16'h0, wrap ? w2[14:0] : w[15:1], dir});
      apb(1'b0, `PFC_A_IN, 32'h0);
      if (dir) chk(rd, chan_data);
      else chk(ch_out_q, w2);
      apb(1'b0, `PFC_A_STAT, 32'h0);
      chk(rd[1], wrap);
      apb(1'b1, `PFC_A_STAT, 32'h2);
    end
    $display("Test channel done");
    w = $urandom;
    f = $urandom;
    apb(1'b1, `PFC_A_TXD, {14'h0, f, w});
    t = 0;
    k = 0;
    cq = 1'b0;
    while (k < 9 && t < 400) begin
      @(posedge pclk);
      t++;
      if (io_clk_out && !cq) begin
        g1 = {g1[7:0], io_data1_out};
        g2 = {g2[7:0], io_data2_out};
        k++;
        chk(io_input, 1'b0);
      end
      cq = io_clk_out;
    end
    chk({g1, g2}, {f[1], w[15:8], f[0], w[7:0]});
    repeat (20) @(posedge pclk);
    chk(io_input, 1'b1);
    r1 = $urandom;
    r2 = $urandom;
    for (int b = 8; b >= 0; b--) begin
      io_d1 <= r1[b];
      io_d2 <= r2[b];
      repeat (4) @(posedge pclk);
      io_clk_in <= 1'b1;
      repeat (4) @(posedge pclk);
      io_clk_in <= 1'b0;
    end
    {io_d1, io_d2} <= ~{io_d1, io_d2};
    repeat (10) @(posedge pclk);
    apb(1'b0, `PFC_A_RXD, 32'h0);
    chk(rd[21:0], {4'h9, r1, r2});
    $display("Test serial link done");
    conclude();
  end
endmodule : pfc_port_tb
`default_nettype wire
